// >>> src/spio_top.sv
`timescale 1ns/1ps
module spio_top (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  // Host side
  input wire logic i_host_reset_n,
  input wire logic i_io_phase,
  input wire logic i_addr_ok,
  input wire logic [4:0] i_nib_addr,
  input wire logic i_nib_wr,
  input wire logic [3:0] i_host_nibble_bus,
  output logic [3:0] o_host_nibble_bus,
  output logic o_host_nibble_oe,
  output logic o_host_access,
  // Configuration switches
  input wire logic [3:0] i_output_count_code,
  input wire logic [1:0] i_scan_rate,
  // External device side
  input wire logic i_start,
  input wire logic [7:0] i_external_data_bus,
  output logic [7:0] o_external_data_bus,
  output logic o_external_data_oe,
  output logic [15:0] o_enable_n,
  output logic o_ready_n
);
  typedef enum logic [1:0] {ST_CLEAR, ST_HOST, ST_WAIT, ST_SCAN} spio_state_e;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [1:0] hrst_s_q;
  logic [1:0] start_s_q;
  logic [7:0] din_m_q;
  logic [7:0] din_q;
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      hrst_s_q <= 2'h0;
      start_s_q <= 2'h0;
      din_m_q <= 8'h00;
      din_q <= 8'h00;
    end else begin
      hrst_s_q <= {hrst_s_q[0], i_host_reset_n};
      start_s_q <= {start_s_q[0], i_start};
      din_m_q <= i_external_data_bus;
      din_q <= din_m_q;
    end
  end
  logic hrst_n;
  logic start_hi;
  assign hrst_n = hrst_s_q[1];
  assign start_hi = start_s_q[1];

  // ----------------------------------------
  // Slot timing
  // ----------------------------------------
  function automatic logic [19:0] slot_len(input logic [1:0] sel);
    unique case (sel)
      2'h0: slot_len = 20'(spio_pkg::SLOT_CYC_0);
      2'h1: slot_len = 20'(spio_pkg::SLOT_CYC_1);
      2'h2: slot_len = 20'(spio_pkg::SLOT_CYC_2);
      2'h3: slot_len = 20'(spio_pkg::SLOT_CYC_3);
    endcase
  endfunction : slot_len

  spio_state_e state_q;
  logic [3:0] slot_q;
  logic [19:0] tick_q;
  logic [1:0] rate_q;
  logic [19:0] period;
  logic [19:0] act_len;
  logic slot_end;
  logic capture;
  logic is_output;
  assign period = slot_len(rate_q); // RL6
  // The product overflows 20 bits for the slower rates, so it is formed in 32 bits.
  assign act_len = 20'((32'(period) * 32'(spio_pkg::ACT_NUM)) / 32'(spio_pkg::ACT_DEN)); // RL17
  assign slot_end = tick_q == period - 20'h1;
  assign capture = tick_q == act_len - 20'(spio_pkg::CAP_LEAD); // RL18
  assign is_output = {1'b0, slot_q} < {1'b0, i_output_count_code}; // RL4

  // ----------------------------------------
  // Phase tracking
  // ----------------------------------------
  logic phase_q;
  logic phase_end;
  logic [3:0] clr_q;
  assign phase_end = phase_q && !i_io_phase;
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      phase_q <= 1'b0;
    end else begin
      phase_q <= i_io_phase;
    end
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst || !hrst_n) begin
      state_q <= ST_CLEAR; // RL12
      clr_q <= 4'h0;
      slot_q <= 4'h0;
      tick_q <= 20'h0;
      rate_q <= 2'h0;
    end else begin
      unique case (state_q)
        ST_CLEAR: begin
          clr_q <= clr_q + 4'h1;
          if (clr_q == 4'(spio_pkg::SLOTS - 1)) begin
            state_q <= ST_HOST; // RL13
          end
        end
        ST_HOST: begin
          if (phase_end) begin
            state_q <= ST_WAIT; // RL9
          end
        end
        ST_WAIT: begin
          if (start_hi) begin // RL10
            state_q <= ST_SCAN;
            slot_q <= 4'h0; // RL5
            tick_q <= 20'h0;
            rate_q <= i_scan_rate; // RL6
          end
        end
        ST_SCAN: begin
          tick_q <= slot_end ? 20'h0 : tick_q + 20'h1;
          if (slot_end) begin
            slot_q <= slot_q + 4'h1; // RL5
            if (slot_q == 4'(spio_pkg::SLOTS - 1)) begin
              state_q <= ST_HOST; // RL7
            end
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // Buffer memory
  // ----------------------------------------
  // Host writes land through the FIFO so a burst of nibble writes never
  // collides with the single buffer write port; the FIFO drains one per cycle, only while in ST_HOST.
  logic [7:0] buf_q [spio_pkg::SLOTS];
  logic host_go;
  logic f_in_valid;
  logic f_in_ready;
  logic f_out_valid;
  logic [11:0] f_out_data;
  logic f_drain;
  assign host_go = state_q == ST_HOST && i_io_phase && i_addr_ok; // RL8 RL11
  assign f_in_valid = host_go && i_nib_wr;
  assign f_drain = state_q == ST_HOST;
  spio_fifo #(
    .WIDTH(spio_pkg::FIFO_WIDTH),
    .DEPTH(spio_pkg::FIFO_DEPTH)
  ) u_fifo (
    .i_ref_clk(i_ref_clk),
    .i_nrst(i_nrst),
    .i_valid(f_in_valid),
    .o_ready(f_in_ready),
    .i_data({3'h0, i_nib_addr, i_host_nibble_bus}),
    .o_valid(f_out_valid),
    .i_ready(f_drain),
    .o_data(f_out_data)
  );

  always_ff @(posedge i_ref_clk) begin
    if (state_q == ST_CLEAR) begin
      buf_q[clr_q] <= spio_pkg::BYTE_RST; // RL12
    end else if (state_q == ST_SCAN && capture && !is_output) begin
      buf_q[slot_q] <= din_q; // RL2 RL18
    end else if (f_out_valid && f_drain) begin
      if (f_out_data[4]) begin
        buf_q[f_out_data[8:5]][7:4] <= f_out_data[3:0]; // RL16
      end else begin
        buf_q[f_out_data[8:5]][3:0] <= f_out_data[3:0]; // RL16
      end
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  logic [3:0] rd_nib_q;
  logic rd_oe_q;
  logic [7:0] dout_q;
  logic dout_oe_q;
  logic [15:0] en_n_q;
  logic ready_n_q;
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      rd_nib_q <= 4'h0;
      rd_oe_q <= 1'b0;
      dout_q <= 8'h00;
      dout_oe_q <= 1'b0;
      en_n_q <= 16'hFFFF;
      ready_n_q <= 1'b1;
    end else begin
      rd_oe_q <= host_go && !i_nib_wr && !f_out_valid;
      rd_nib_q <= i_nib_addr[0] ? buf_q[i_nib_addr[4:1]][7:4] : buf_q[i_nib_addr[4:1]][3:0];
      en_n_q <= 16'hFFFF;
      if (state_q == ST_SCAN && tick_q < act_len) begin
        en_n_q[slot_q] <= 1'b0; // RL14
      end
      dout_oe_q <= state_q == ST_SCAN && is_output; // RL3
      dout_q <= buf_q[slot_q]; // RL3
      ready_n_q <= !(state_q == ST_HOST && hrst_n); // RL15 RL7
    end
  end

  assign o_host_nibble_bus = rd_nib_q;
  assign o_host_nibble_oe = rd_oe_q;
  assign o_host_access = state_q == ST_HOST;
  assign o_external_data_bus = dout_q;
  assign o_external_data_oe = dout_oe_q;
  assign o_enable_n = en_n_q; // RL1
  assign o_ready_n = ready_n_q;
  logic unused_ok;
  assign unused_ok = f_in_ready ^ ^f_out_data[11:9];
endmodule : spio_top

// >>> src/spio_pkg.sv
// Functional notes
// RL1: Sixteen enables, buffer of 16 bytes.
// RL2: Input slot byte stored into buffer.
// RL3: Output slot drives buffer byte onto bus.
// RL4: Low lines outputs; count from code.
// RL5: Scan ascending, line 0 to 15.
// RL6: Scan rate chosen by static switches.
// RL7: After scan stop, ready, grant host access.
// RL8: Host transfers only during addressed I/O phase.
// RL9: Phase end withdraws access, scan if start.
// RL10: Start low postpones scan until high.
// RL11: Scanning ignores host addressing, no stretching.
// RL12: Host reset low clears buffer to zero.
// RL13: After reset, one exchange, then scan.
// RL14: Enables active low, one at a time.
// RL15: Ready driven low when scan finished.
// RL16: Byte maps to two nibbles, low first.
// RL17: Enable active 0.8 of slot period.
// RL18: Input byte captured before enable release.
package spio_pkg;
  // ----------------------------------------
  // Scan geometry
  // ----------------------------------------
  localparam int unsigned SLOTS = 16;
  localparam int unsigned SLOT_W = 4;
  localparam int unsigned NIB_PLACES = 32;
  localparam logic [7:0] BYTE_RST = 8'h00;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned SLOT_US_0 = 320;
  localparam int unsigned SLOT_US_1 = 640;
  localparam int unsigned SLOT_US_2 = 1280;
  localparam int unsigned SLOT_US_3 = 2560;
  localparam int unsigned SLOT_CYC_0 = SLOT_US_0 * CLK_MHZ;
  localparam int unsigned SLOT_CYC_1 = SLOT_US_1 * CLK_MHZ;
  localparam int unsigned SLOT_CYC_2 = SLOT_US_2 * CLK_MHZ;
  localparam int unsigned SLOT_CYC_3 = SLOT_US_3 * CLK_MHZ;
  // Enable active for eight tenths of a slot; capture two cycles before release.
  localparam int unsigned ACT_NUM = 8;
  localparam int unsigned ACT_DEN = 10;
  localparam int unsigned CAP_LEAD = 2;
  localparam int unsigned CNT_W = 20;
  localparam int unsigned FIFO_DEPTH = 8;
  localparam int unsigned FIFO_WIDTH = 12;
endpackage : spio_pkg

// >>> src/spio_fifo.sv
`timescale 1ns/1ps
module spio_fifo #(
  parameter int unsigned WIDTH = 12,
  parameter int unsigned DEPTH = 8
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  // Fill side
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [WIDTH-1:0] i_data,
  // Drain side
  output logic o_valid,
  input wire logic i_ready,
  output logic [WIDTH-1:0] o_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  // Room is left whenever fewer than DEPTH words are held.
  assign o_ready = cnt_q < (AW+1)'(DEPTH);
  assign o_valid = cnt_q != '0;
  assign push = i_valid && o_ready;
  assign pop = o_valid && i_ready;
  assign o_data = mem_q[rd_q];

  always_ff @(posedge i_ref_clk) begin
    if (push) begin
      mem_q[wr_q] <= i_data;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : spio_fifo

// >>> dv/spio_chk_sva.sv
`timescale 1ns/1ps
module spio_chk (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  // Watched ports
  input wire logic i_io_phase,
  input wire logic i_addr_ok,
  input wire logic i_nib_wr,
  input wire logic [1:0] i_scan_rate,
  input wire logic o_host_nibble_oe,
  input wire logic o_host_access,
  input wire logic o_external_data_oe,
  input wire logic [15:0] o_enable_n,
  input wire logic o_ready_n
);
  int low_q;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);
  always_ff @(posedge i_ref_clk) begin
    low_q <= (&o_enable_n) ? 0 : low_q + 1;
  end
  one_enable_a: assert property ($onehot0(~o_enable_n))
    else $error("two enables low");
  reset_idle_a: assert property (disable iff (1'b0) !i_nrst |=>
    &o_enable_n && o_ready_n && !o_external_data_oe) else $error("reset not idle");
  ready_idle_a: assert property ($fell(o_ready_n) |->
    &o_enable_n && !o_external_data_oe) else $error("ready during scan");
  access_idle_a: assert property (o_host_access |->
    &o_enable_n && !o_external_data_oe) else $error("access during scan");
  read_cause_a: assert property (o_host_nibble_oe |-> $past(i_io_phase) &&
    $past(i_addr_ok) && !$past(i_nib_wr) && $past(o_host_access)) else $error("bad read");
  one_step_a: assert property ($changed(o_enable_n) |->
    $past(o_enable_n) == 16'hFFFF || o_enable_n == 16'hFFFF) else $error("enable hop");
  pulse_len_a: assert property ($rose(&o_enable_n) && $past(i_nrst) &&
    i_scan_rate == 2'h0 |-> low_q == 51200) else $error("pulse length");
  phase_end_a: assert property ($fell(i_io_phase) && $past(o_host_access) |->
    ##[0:3] !o_host_access) else $error("access kept");
endmodule : spio_chk

// >>> dv/spio_dev.sv
`timescale 1ns/1ps
module spio_dev (
  // Clock
  input wire logic i_ref_clk,
  // Scan side
  input wire logic [15:0] i_enable_n,
  input wire logic [3:0] i_out_cnt,
  input wire logic [7:0] i_bus,
  input wire logic i_bus_oe,
  output logic [7:0] o_bus,
  output logic [7:0] o_seen
);
  // An unselected bus floats; a rolling pattern keeps stale data from passing.
  logic [7:0] roll_q = 8'h00;
  always_ff @(posedge i_ref_clk) begin
    roll_q <= roll_q + 8'h35;
    if (i_enable_n != 16'hFFFF && i_bus_oe) o_seen <= i_bus;
  end
  always_comb begin
    o_bus = roll_q;
    for (int k = 0; k < 16; k++)
      if (!i_enable_n[k] && k >= int'(i_out_cnt)) o_bus = 8'hC3 ^ 8'(k);
  end
endmodule : spio_dev

// >>> dv/tb_spio_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin err_total++; \
  $display("MISMATCH %0t value differs", $time); end end
module tb_spio_top;
  logic i_ref_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic i_host_reset_n = 1'b1;
  logic i_io_phase = 1'b0;
  logic i_addr_ok = 1'b0;
  logic [4:0] i_nib_addr = 5'h00;
  logic i_nib_wr = 1'b0;
  logic [3:0] i_host_nibble_bus = 4'h0;
  logic [3:0] i_output_count_code = 4'h1;
  logic [1:0] i_scan_rate = 2'h0;
  logic i_start = 1'b0;
  logic [3:0] o_host_nibble_bus;
  logic o_host_nibble_oe, o_host_access, o_external_data_oe, o_ready_n;
  logic [7:0] i_external_data_bus, o_external_data_bus, seen;
  logic [15:0] o_enable_n;
  logic [3:0] mem [32];
  int err_total = 0;
  int comparisons = 0;
  int cyc_q = 0;
  int n;
  spio_top dut (.i_ref_clk, .i_nrst, .i_host_reset_n, .i_io_phase, .i_addr_ok, .i_nib_addr,
    .i_nib_wr, .i_host_nibble_bus, .o_host_nibble_bus, .o_host_nibble_oe, .o_host_access,
    .i_output_count_code, .i_scan_rate, .i_start, .i_external_data_bus,
    .o_external_data_bus, .o_external_data_oe, .o_enable_n, .o_ready_n);
  spio_dev dev (.i_ref_clk, .i_enable_n(o_enable_n), .i_out_cnt(i_output_count_code),
    .i_bus(o_external_data_bus), .i_bus_oe(o_external_data_oe),
    .o_bus(i_external_data_bus), .o_seen(seen));
  initial begin
    forever #2.5 i_ref_clk = ~i_ref_clk;
  end
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : complete_run
  always @(posedge i_ref_clk) begin
    cyc_q <= cyc_q + 1;
    if (cyc_q == 90000) begin
      err_total++;
      complete_run();
    end
  end
  task automatic acc(input logic [4:0] a, input logic wr, input logic [3:0] d);
    @(posedge i_ref_clk);
    i_io_phase <= 1'b1;
    i_addr_ok <= 1'b1;
    i_nib_wr <= wr;
    i_nib_addr <= a;
    i_host_nibble_bus <= d;
    if (wr) mem[a] = d;
  endtask : acc
  task automatic idle(input int c);
    @(posedge i_ref_clk);
    i_addr_ok <= 1'b0;
    repeat (c) @(posedge i_ref_clk);
  endtask : idle
  task automatic sweep;
    for (int a = 0; a < 32; a++) begin
      acc(5'(a), 1'b0, 4'h0);
      @(posedge i_ref_clk);
      #1;
      `CHK(o_host_nibble_oe, 1'b1)
      `CHK(o_host_nibble_bus, mem[a])
    end
    idle(1);
  endtask : sweep
  task automatic await(input int lim);
    n = 0;
    while (o_host_access !== 1'b1 && n < lim) begin
      @(posedge i_ref_clk);
      #1;
      n++;
    end
    `CHK(o_host_access, 1'b1)
  endtask : await
  initial begin
    n = $urandom(32'h23673604);
    foreach (mem[i]) mem[i] = 4'h0;
    repeat (8) @(posedge i_ref_clk);
    i_nrst <= 1'b1;
    await(300);
    sweep();
    $display("clear test done");
    for (int b = 0; b < 32; b += 4) begin
      for (int k = b; k < b + 4; k++) acc(5'(k), 1'b1, 4'($urandom));
      idle(20);
    end
    sweep();
    $display("write test done");
    i_host_reset_n <= 1'b0;
    repeat (4) @(posedge i_ref_clk);
    i_host_reset_n <= 1'b1;
    foreach (mem[i]) mem[i] = 4'h0;
    await(300);
    sweep();
    acc(5'h00, 1'b1, 4'($urandom));
    acc(5'h01, 1'b1, 4'($urandom));
    idle(20);
    i_io_phase <= 1'b0;
    repeat (50) @(posedge i_ref_clk);
    #1;
    `CHK(o_enable_n, 16'hFFFF)
    `CHK(o_host_access, 1'b0)
    @(posedge i_ref_clk);
    i_start <= 1'b1;
    n = 0;
    while (o_enable_n[0] !== 1'b0 && n < 100) begin
      @(posedge i_ref_clk);
      #1;
      n++;
    end
    `CHK(o_enable_n, 16'hFFFE)
    `CHK(o_external_data_oe, 1'b1)
    `CHK(o_external_data_bus, {mem[1], mem[0]})
    for (int s = 0; s < 2; s++) begin
      n = 0;
      while (o_enable_n[s] == s[0] && n < 60000) begin
        @(posedge i_ref_clk);
        #1;
        n++;
      end
      `CHK(n, s ? 12800 : 51200)
    end
    `CHK(seen, {mem[1], mem[0]})
    `CHK(o_enable_n, 16'hFFFD)
    `CHK(o_external_data_oe, 1'b0)
    acc(5'h02, 1'b0, 4'h0);
    repeat (2) @(posedge i_ref_clk);
    #1;
    `CHK(o_host_nibble_oe, 1'b0)
    $display("scan test done");
    complete_run();
  end
endmodule : tb_spio_top
bind spio_top spio_chk chk (.i_ref_clk, .i_nrst, .i_io_phase, .i_addr_ok, .i_nib_wr,
  .i_scan_rate, .o_host_nibble_oe, .o_host_access, .o_external_data_oe, .o_enable_n,
  .o_ready_n);
